// ===== logic/nvb_ctrl.sv
// module: byte-wide access controller for the 32x8 non-volatile data store
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: provide 32 by 8 store, not memory mapped
// RULE2: each access moves exactly one byte
// RULE3: location index five bits, upper bits zero
// RULE4: byte buffer full eight bits, reset zero
// RULE5: index and buffer directly addressed in bank 0
// RULE6: software sets pointer 40H, bank 01H first
// RULE7: control bits 3..0, upper bits read zero
// RULE8: write permit clear blocks all writes
// RULE9: write go starts only with permit set
// RULE10: hardware clears write go when write ends
// RULE11: read permit clear blocks all reads
// RULE12: read go starts only with permit set
// RULE13: hardware clears read go, byte in buffer
// RULE14: software never sets both go bits together
// RULE15: read order: permit, index, then go
// RULE16: buffer keeps fetched byte until next access
// RULE17: software trusts buffer after read go clears
// RULE18: write go set right after write permit
// RULE19: write length set by separate internal timer
// RULE20: write end sets done flag, cleared on service
// RULE21: write stores buffer at latched start index
module nvb_ctrl #(
    parameter int TICK_DIV = nvb_pkg::NVB_TICK_DIV, // clk cycles per timer tick
    parameter int WRITE_TICKS = nvb_pkg::NVB_WRITE_TICKS // timer ticks per write
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // special function register port
    input wire nvb_pkg::nvb_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // interrupt request
    input wire logic irq_serviced,
    output logic write_done_irq_flag,
    // status
    output logic store_busy
);
    import nvb_pkg::*;

    // =====================================================
    // decode helpers
    // true when an access reaches the control register, directly never
    function automatic logic hits_control(input logic [7:0] a, input logic [7:0] ptr,
                                          input logic bank);
        hits_control = (a == NVB_ADDR_IND_PORT_ONE) && (ptr == NVB_ADDR_CONTROL)
                       && (bank == NVB_CONTROL_BANK);
    endfunction

    // =====================================================
    // state
    logic [7:0] store_mem [NVB_DEPTH]; // the non-volatile array [RULE1]
    logic [NVB_INDEX_W-1:0] loc_index_q, loc_index_d; // location index bits
    logic [7:0] byte_buf_q, byte_buf_d; // byte buffer bits
    logic [7:0] ind_ptr_q, ind_ptr_d; // indirect pointer one
    logic bank_q, bank_d; // bank select, bit 0 only
    nvb_control_t ctrl_q, ctrl_d; // control register
    nvb_state_t state_q, state_d; // access sequencer
    logic [NVB_INDEX_W-1:0] wr_index_q, wr_index_d; // index latched at write start
    logic [15:0] div_q, div_d; // timer prescaler
    logic [15:0] cnt_q, cnt_d; // cycle length counter
    logic irq_q, irq_d; // write done request
    logic [7:0] rdata_q, rdata_d; // registered read answer
    logic tick; // one-cycle timer enable
    logic ctrl_wr; // software write to control
    logic store_we; // commit a byte to the array
    logic [7:0] ctrl_byte; // control as read back

    // =====================================================
    // write timer divider: a slow enable standing in for the separate timer,
    // so a write lasts many clk cycles and software must poll [RULE19]
    assign tick = (div_q == 16'(TICK_DIV - 1));

    assign ctrl_wr = sfr_req.wr && hits_control(sfr_req.addr, ind_ptr_q, bank_q); // [RULE6]
    // upper four bits are unimplemented and read zero [RULE7]
    assign ctrl_byte = {4'h0, ctrl_q.write_permit_bit, ctrl_q.write_go,
                        ctrl_q.read_permit_bit, ctrl_q.read_go};

    // =====================================================
    // next-state logic for registers and sequencer
    always_comb begin
        loc_index_d = loc_index_q;
        byte_buf_d = byte_buf_q;
        ind_ptr_d = ind_ptr_q;
        bank_d = bank_q;
        ctrl_d = ctrl_q;
        state_d = state_q;
        wr_index_d = wr_index_q;
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
        cnt_d = cnt_q;
        irq_d = irq_q;
        store_we = 1'b0;

        // direct software writes
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                NVB_ADDR_LOC_INDEX: begin
                    loc_index_d = sfr_req.wdata[NVB_INDEX_W-1:0]; // [RULE3] [RULE5]
                end
                NVB_ADDR_BYTE_BUF: begin
                    byte_buf_d = sfr_req.wdata; // [RULE4] [RULE5]
                end
                NVB_ADDR_IND_PTR_ONE: begin
                    ind_ptr_d = sfr_req.wdata;
                end
                NVB_ADDR_BANK_SELECT: begin
                    bank_d = sfr_req.wdata[0];
                end
                default: begin
                    // unmapped or indirect: handled below or ignored
                end
            endcase
        end

        // control register write: permit bits are plain, go bits only set
        if (ctrl_wr) begin
            ctrl_d.write_permit_bit = sfr_req.wdata[NVB_WRITE_PERMIT_POS];
            ctrl_d.read_permit_bit = sfr_req.wdata[NVB_READ_PERMIT_POS];
        end

        unique case (state_q)
            NVB_IDLE: begin
                // go needs the permit already stored, so one write
                // setting both only stores the permit and starts no write [RULE9] [RULE8]
                if (ctrl_wr && sfr_req.wdata[NVB_WRITE_GO_POS] && ctrl_q.write_permit_bit) begin
                    ctrl_d.write_go = 1'b1;
                    wr_index_d = loc_index_q; // [RULE21]
                    cnt_d = 16'h0000;
                    state_d = NVB_WRITING;
                end else if (ctrl_wr && sfr_req.wdata[NVB_READ_GO_POS]
                             && ctrl_q.read_permit_bit) begin
                    // write wins if software breaks the one-go rule [RULE12] [RULE11] [RULE14]
                    ctrl_d.read_go = 1'b1;
                    cnt_d = 16'h0000;
                    state_d = NVB_READING;
                end
            end
            NVB_WRITING: begin
                if (tick) begin
                    cnt_d = cnt_q + 16'h0001;
                end
                // end of write: store, self-clear go, raise request
                if (tick && (cnt_q == 16'(WRITE_TICKS - 1))) begin
                    store_we = 1'b1; // [RULE21] [RULE2]
                    ctrl_d.write_go = 1'b0; // [RULE10]
                    irq_d = 1'b1; // [RULE20]
                    state_d = NVB_IDLE;
                end
            end
            NVB_READING: begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(NVB_READ_CYCLES - 1)) begin
                    // fetched byte overrides a same-cycle buffer write [RULE13] [RULE16]
                    byte_buf_d = store_mem[loc_index_q];
                    ctrl_d.read_go = 1'b0; // [RULE13]
                    state_d = NVB_IDLE;
                end
            end
            default: begin
                state_d = NVB_IDLE;
            end
        endcase

        // service clears the request, a new completion wins [RULE20]
        if (irq_serviced && !store_we) begin
            irq_d = 1'b0;
        end
    end

    // =====================================================
    // read answer mux, registered one cycle after the strobe
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_req.rd) begin
            if (hits_control(sfr_req.addr, ind_ptr_q, bank_q)) begin
                rdata_d = ctrl_byte; // [RULE7]
            end else if (sfr_req.addr == NVB_ADDR_LOC_INDEX) begin
                rdata_d = {3'b000, loc_index_q}; // upper bits zero [RULE3]
            end else if (sfr_req.addr == NVB_ADDR_BYTE_BUF) begin
                rdata_d = byte_buf_q; // [RULE4]
            end else if (sfr_req.addr == NVB_ADDR_IND_PTR_ONE) begin
                rdata_d = ind_ptr_q;
            end else if (sfr_req.addr == NVB_ADDR_BANK_SELECT) begin
                rdata_d = {7'h00, bank_q};
            end else begin
                rdata_d = NVB_UNMAPPED_READ;
            end
        end
    end

    // =====================================================
    // register stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loc_index_q <= '0;
            byte_buf_q <= NVB_RESET_BYTE;
            ind_ptr_q <= NVB_RESET_BYTE;
            bank_q <= 1'b0;
            ctrl_q <= '0; // all permits and go bits clear [RULE7]
            state_q <= NVB_IDLE;
            wr_index_q <= '0;
            div_q <= 16'h0000;
            cnt_q <= 16'h0000;
            irq_q <= 1'b0;
            rdata_q <= NVB_RESET_BYTE;
        end else begin
            loc_index_q <= loc_index_d;
            byte_buf_q <= byte_buf_d;
            ind_ptr_q <= ind_ptr_d;
            bank_q <= bank_d;
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            wr_index_q <= wr_index_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // =====================================================
    // array: no reset, contents are non-volatile
    always_ff @(posedge clk) begin
        if (store_we) begin
            store_mem[wr_index_q] <= byte_buf_q; // [RULE21]
        end
    end

    // =====================================================
    // outputs
    assign sfr_rdata = rdata_q;
    assign write_done_irq_flag = irq_q;
    assign store_busy = (state_q != NVB_IDLE);

endmodule
`default_nettype wire

// ===== logic/nvb_pkg.sv
// package: register map, field layout, reset values and types of the byte store access block
package nvb_pkg;

    // =====================================================
    // special function register addresses
    localparam logic [7:0] NVB_ADDR_IND_PORT_ONE = 8'h02; // indirect access port one
    localparam logic [7:0] NVB_ADDR_IND_PTR_ONE = 8'h03; // indirect pointer one
    localparam logic [7:0] NVB_ADDR_BANK_SELECT = 8'h04; // bank select
    localparam logic [7:0] NVB_ADDR_LOC_INDEX = 8'h1E; // location index, bank 0
    localparam logic [7:0] NVB_ADDR_BYTE_BUF = 8'h1F; // byte buffer, bank 0
    localparam logic [7:0] NVB_ADDR_CONTROL = 8'h40; // control, bank 1 only
    localparam logic NVB_CONTROL_BANK = 1'b1; // bank holding the control register

    // =====================================================
    // field positions and reset values
    localparam int NVB_WRITE_PERMIT_POS = 3;
    localparam int NVB_WRITE_GO_POS = 2;
    localparam int NVB_READ_PERMIT_POS = 1;
    localparam int NVB_READ_GO_POS = 0;
    localparam int NVB_INDEX_W = 5; // location index bits
    localparam int NVB_DEPTH = 32; // locations in the store
    localparam logic [7:0] NVB_RESET_BYTE = 8'h00; // every register after reset
    localparam logic [7:0] NVB_UNMAPPED_READ = 8'h00; // answer for unknown addresses

    // =====================================================
    // timing: write length is set by a slow timer tick, in cycles of clk
    localparam int NVB_TICK_DIV = 16; // clk cycles per timer tick
    localparam int NVB_WRITE_TICKS = 64; // timer ticks per write cycle
    localparam int NVB_READ_CYCLES = 2; // clk cycles per read cycle

    // =====================================================
    // types
    typedef enum logic [1:0] {
        NVB_IDLE = 2'b00,
        NVB_WRITING = 2'b01,
        NVB_READING = 2'b10
    } nvb_state_t;

    typedef struct packed {
        logic write_permit_bit;
        logic write_go;
        logic read_permit_bit;
        logic read_go;
    } nvb_control_t;

    typedef struct packed {
        logic [7:0] addr; // special function register address
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [7:0] wdata; // write data
    } nvb_sfr_req_t;

endpackage

// ===== testbench/nvb_ctrl_asserts.sv
// checker: port-level properties of the byte store access controller
`timescale 1ns/1ps
`default_nettype none
module nvb_ctrl_asserts #(
    parameter int TICK_DIV = 16,
    parameter int WRITE_TICKS = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire nvb_pkg::nvb_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_serviced,
    input wire logic write_done_irq_flag,
    input wire logic store_busy
);
    import nvb_pkg::*;
    // =====================================================
    // helper logic
    localparam int W_MAX = TICK_DIV * (WRITE_TICKS + 1) + 4; // longest write, phase slack
    int busy_cnt_q, busy_cnt_d; // consecutive busy cycles
    logic wkind_q, wkind_d; // last idle control write asked for a write
    always_comb begin
        busy_cnt_d = store_busy ? busy_cnt_q + 1 : 0;
        wkind_d = wkind_q;
        if (sfr_req.wr && sfr_req.addr == 8'h02 && !store_busy) begin
            wkind_d = sfr_req.wdata[2];
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_q <= 0;
            wkind_q <= 1'b0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            wkind_q <= wkind_d;
        end
    end
    // =====================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence read_start;
        $rose(store_busy) && !wkind_q;
    endsequence
    sequence read_run;
        store_busy [*2] ##1 !store_busy;
    endsequence
    // any reset leaves nothing running and the registered answer at zero
    a_reset_quiet: assert property (
        $rose(reset_n) |-> !store_busy && !write_done_irq_flag && sfr_rdata == 8'h00)
        else $error("outputs not idle after reset");
    // holes in the bank 0 map answer zero one cycle after the strobe
    a_unmapped_zero: assert property (
        sfr_req.rd && sfr_req.addr inside {[8'h05:8'h1D]} |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_index_upper: assert property (
        sfr_req.rd && sfr_req.addr == 8'h1E |=> sfr_rdata[7:5] == 3'h0)
        else $error("index upper bits not zero");
    // a cycle only ever follows a write through the indirect port
    a_start_cause: assert property (
        $rose(store_busy) |-> $past(sfr_req.wr) && $past(sfr_req.addr) == 8'h02)
        else $error("cycle started without control write");
    a_read_length: assert property (
        read_start |-> read_run ##0 !$rose(write_done_irq_flag))
        else $error("read cycle length wrong");
    a_write_flag: assert property (
        $fell(store_busy) && wkind_q |-> write_done_irq_flag)
        else $error("write end did not set flag");
    a_flag_cause: assert property ($rose(write_done_irq_flag) |-> $fell(store_busy))
        else $error("flag rose without write end");
    a_service_clear: assert property (
        irq_serviced && !store_busy |=> !write_done_irq_flag)
        else $error("service did not clear flag");
    a_answer_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read answer changed without read");
    a_busy_bounded: assert property (busy_cnt_q <= W_MAX)
        else $error("cycle ran too long");
endmodule
bind nvb_ctrl nvb_ctrl_asserts #(.TICK_DIV(TICK_DIV), .WRITE_TICKS(WRITE_TICKS)) nvb_ctrl_asserts_i (
    .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_serviced(irq_serviced), .write_done_irq_flag(write_done_irq_flag),
    .store_busy(store_busy));
`default_nettype wire

// ===== testbench/nvb_ctrl_tb_top.sv
// testbench: register-level stimulus and checks for the byte store controller
`timescale 1ns/1ps
`default_nettype none
module nvb_ctrl_tb_top;
    import nvb_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    nvb_sfr_req_t sfr_req = '0;
    logic irq_serviced = 1'b0;
    logic [7:0] sfr_rdata;
    logic write_done_irq_flag, store_busy;
    int failures = 0;
    int n_compared = 0;
    logic [7:0] mem [32]; // expected store contents
    logic [4:0] idx [6]; // locations used by the random loop
    always #2.5 clk = ~clk;
    // short write so the run stays brief, yet long enough to poll the go bit
    nvb_ctrl #(.TICK_DIV(2), .WRITE_TICKS(4)) nvb_ctrl_i (.clk(clk), .reset_n(reset_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq_serviced(irq_serviced),
        .write_done_irq_flag(write_done_irq_flag), .store_busy(store_busy));
    // =====================================================
    // helpers
    function automatic logic [7:0] idx_exp(input logic [7:0] d);
        return {3'h0, d[4:0]}; // upper bits unimplemented
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk) sfr_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk) sfr_req <= '0;
        #1 check(sfr_rdata, exp);
    endtask
    task automatic wait_idle();
        int n;
        #1 n = 0;
        while (store_busy !== 1'b0 && n < 100) begin
            @(posedge clk) #1 n++;
        end
        // a cycle that never ends counts as a mismatch
        if (n >= 100) begin
            failures++;
            $display("FAIL %0t cycle did not end", $time);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // =====================================================
    // main sequence
    initial begin
        logic [7:0] d;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        void'($urandom(49044));
        foreach (mem[i]) mem[i] = 8'h00;
        foreach (idx[i]) idx[i] = 5'(i * 7 + 3);
        rd(8'h1E, 8'h00);
        rd(8'h1F, 8'h00);
        rd(8'h02, 8'h00); // indirect port before bank switch
        wr(8'h10, 8'hA5);
        rd(8'h10, 8'h00);
        wr(8'h1E, 8'hFF);
        rd(8'h1E, idx_exp(8'hFF));
        d = 8'($urandom);
        wr(8'h1F, d);
        rd(8'h1F, d);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h40);
        rd(8'h02, 8'h00);
        wr(8'h02, 8'hF4); // go without permit, upper bits set
        #1 check({7'h0, store_busy}, 8'h00);
        rd(8'h02, 8'h00);
        wr(8'h02, 8'h01);
        #1 check({7'h0, store_busy}, 8'h00);
        foreach (idx[i]) begin
            d = 8'($urandom);
            mem[idx[i]] = d;
            wr(8'h1E, {3'h0, idx[i]});
            wr(8'h1F, d);
            wr(8'h02, 8'h08);
            wr(8'h02, 8'h0C); // only one go bit per write
            rd(8'h02, 8'h0C);
            wr(8'h1E, 8'h00); // index change must not move the write
            wait_idle();
            check({7'h0, write_done_irq_flag}, 8'h01);
            rd(8'h02, 8'h08);
            @(posedge clk) irq_serviced <= 1'b1;
            @(posedge clk) irq_serviced <= 1'b0;
            #1 check({7'h0, write_done_irq_flag}, 8'h00);
        end
        wr(8'h1F, 8'h5A);
        wr(8'h1E, {3'h0, idx[0]});
        wr(8'h02, 8'h00);
        wr(8'h02, 8'h04); // write go with permit cleared
        #1 check({7'h0, store_busy}, 8'h00);
        wr(8'h02, 8'h01);
        rd(8'h1F, 8'h5A);
        foreach (idx[i]) begin
            wr(8'h02, 8'h02);
            wr(8'h1E, {3'h0, idx[i]});
            wr(8'h02, 8'h03);
            wait_idle();
            rd(8'h02, 8'h02);
            rd(8'h1F, mem[idx[i]]);
            rd(8'h1E, {3'h0, idx[i]});
            rd(8'h1F, mem[idx[i]]);
        end
        // second reset in mid-run, asserted on a rising edge
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h1F, 8'h00);
        conclude();
    end
    // watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
